// >>> design/csm_pkg.sv
// Constants for the card strobe timing and SDRAM mode-set block.
// Assumes one 200 MHz clock; the external bus clock is half that rate.
package csm_pkg;
  // Register byte addresses
  localparam logic [31:0] ADDR_TIMING = 32'h0000_0000;
  localparam logic [31:0] ADDR_WAITLO = 32'h0000_0004;
  localparam logic [31:0] ADDR_CONFIG = 32'h0000_0008;
  localparam logic [31:0] ADDR_STATUS = 32'h0000_000c;
  localparam logic [31:0] MODE_BASE_A2 = 32'hffff_d000;
  localparam logic [31:0] MODE_BASE_A3 = 32'hffff_e000;
  localparam logic [31:0] MODE_WIN_MASK = 32'hffff_f000;
  // Timing register fields
  localparam int A6_WAIT_HI = 15;
  localparam int A5_WAIT_HI = 14;
  localparam logic [15:0] TIMING_RSVD = 16'h3000;
  localparam logic [15:0] TIMING_RESET = 16'h0000;
  localparam int A5_TED2 = 11, A5_TED1 = 7, A5_TED0 = 6;
  localparam int A6_TED2 = 10, A6_TED1 = 5, A6_TED0 = 4;
  localparam int A5_TEH2 = 9, A5_TEH1 = 3, A5_TEH0 = 2;
  localparam int A6_TEH2 = 8, A6_TEH1 = 1, A6_TEH0 = 0;
  // Low wait bits register: area 5 in [2:0], area 6 in [5:3]
  localparam logic [2:0] WAITLO_RESET = 3'h7;
  localparam logic CONFIG_RESET_BUS32 = 1'b1;
  // Half-cycles of the bus clock per ref_clk cycle
  localparam int REF_CLK_MHZ = 200;
  localparam int BUS_CLK_MHZ = 100;
  localparam int HALF_PER_REF = (2 * BUS_CLK_MHZ) / REF_CLK_MHZ;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_SETUP = 2'b01,
    SEQ_STROBE = 2'b10,
    SEQ_HOLD = 2'b11
  } csm_seq_t;
endpackage

// >>> design/csm_card_timing.sv
// Card strobe timing registers, card cycle sequencer and SDRAM mode set.
// Assumes an AXI4-Lite master and synchronous card and wait inputs.
//
// The AXI4-Lite register port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module csm_card_timing
  import csm_pkg::*;
(
  // Clock and resets
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic manual_rst_n,
  // AXI4-Lite slave
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Card cycle request and strobes
  input wire logic card_req,
  input wire logic card_area6,
  input wire logic card_wait,
  output logic card_busy,
  output logic card_addr_valid,
  output logic card_strobe_n,
  output logic card_done,
  output logic bus_clk_phase,
  // Decoded wait settings per area
  output logic [5:0] area5_wait_states,
  output logic [5:0] area5_burst_states,
  output logic area5_wait_pin_en,
  output logic [5:0] area6_wait_states,
  output logic [5:0] area6_burst_states,
  output logic area6_wait_pin_en,
  // SDRAM mode-set command
  output logic mode_set_cmd,
  output logic mode_set_area3,
  output logic [11:0] mode_set_addr
);

  ////////////////////////////////////////////////////////////////////////
  // Wait code table, shared by both areas
  function automatic logic [5:0] wait_states(input logic [3:0] code);
    logic [5:0] w;
    w = 6'h00;
    unique case (code)
      4'h0: w = 6'd0;
      4'h1: w = 6'd1;
      4'h2: w = 6'd2;
      4'h3: w = 6'd3;
      4'h4: w = 6'd4;
      4'h5: w = 6'd6;
      4'h6: w = 6'd8;
      4'h7: w = 6'd10;
      4'h8: w = 6'd12;
      4'h9: w = 6'd14;
      4'ha: w = 6'd18;
      4'hb: w = 6'd22;
      4'hc: w = 6'd26;
      4'hd: w = 6'd30;
      4'he: w = 6'd34;
      4'hf: w = 6'd38;
    endcase
    return w;
  endfunction

  // Burst states: one more than waits, but never below two
  function automatic logic [5:0] burst_states(input logic [3:0] code);
    return (code == 4'h0) ? 6'd2 : 6'(wait_states(code) + 6'd1);
  endfunction

  // A delay code in half cycles: 2 * code + 1
  function automatic logic [7:0] half_count(input logic [2:0] code);
    return {4'h0, code, 1'b1};
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Reset release through two flip-flops
  logic rst_meta;
  logic rst_n;
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registers
  logic [15:0] timing;
  logic [2:0] a5_wait_lo;
  logic [2:0] a6_wait_lo;
  logic bus32;
  logic [7:0] mode_a2;
  logic [7:0] mode_a3;
  logic [11:0] last_mode;

  // Codes joined from the high bit and the low bits
  wire [3:0] a5_code = {timing[A5_WAIT_HI], a5_wait_lo};
  wire [3:0] a6_code = {timing[A6_WAIT_HI], a6_wait_lo};
  wire [2:0] a5_ted = {timing[A5_TED2], timing[A5_TED1], timing[A5_TED0]};
  wire [2:0] a6_ted = {timing[A6_TED2], timing[A6_TED1], timing[A6_TED0]};
  wire [2:0] a5_teh = {timing[A5_TEH2], timing[A5_TEH1], timing[A5_TEH0]};
  wire [2:0] a6_teh = {timing[A6_TEH2], timing[A6_TEH1], timing[A6_TEH0]};

  // Same table for both areas
  assign area5_wait_states = wait_states(a5_code);
  assign area6_wait_states = wait_states(a6_code);
  assign area5_burst_states = burst_states(a5_code);
  assign area6_burst_states = burst_states(a6_code);
  assign area5_wait_pin_en = (a5_code != 4'h0);
  assign area6_wait_pin_en = (a6_code != 4'h0);

  ////////////////////////////////////////////////////////////////////////
  // AXI write path; address and data may arrive in either order
  logic [31:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic aw_have;
  logic w_have;
  assign s_axi_awready = !aw_have && !s_axi_bvalid;
  assign s_axi_wready = !w_have && !s_axi_bvalid;

  wire do_write = aw_have && w_have && !s_axi_bvalid;
  wire wr_timing = do_write && (aw_addr == ADDR_TIMING);
  wire wr_waitlo = do_write && (aw_addr == ADDR_WAITLO);
  wire wr_config = do_write && (aw_addr == ADDR_CONFIG);
  wire wr_status = do_write && (aw_addr == ADDR_STATUS);
  wire in_win_a2 = (aw_addr & MODE_WIN_MASK) == MODE_BASE_A2;
  wire in_win_a3 = (aw_addr & MODE_WIN_MASK) == MODE_BASE_A3;
  wire wr_mode = do_write && (in_win_a2 || in_win_a3);
  wire wr_ok = wr_timing || wr_waitlo || wr_config || wr_status || wr_mode;

  // Mode value from the address offset only; data is dropped
  wire [11:0] mode_off = aw_addr[11:0];
  wire [11:0] mode_val = bus32 ? {2'h0, mode_off[11:2]}
                               : {1'h0, mode_off[11:1]};

  // Timing byte merge; reserved bits never stored
  wire [15:0] timing_merge = {
    s_axi_wstrb_sel(w_strb[1], w_data[15:8], timing[15:8]),
    s_axi_wstrb_sel(w_strb[0], w_data[7:0], timing[7:0])};
  function automatic logic [7:0] s_axi_wstrb_sel(input logic en,
      input logic [7:0] nv, input logic [7:0] ov);
    return en ? nv : ov;
  endfunction

  // Capture write address and data
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_have <= 1'b0;
      w_have <= 1'b0;
      aw_addr <= 32'h0000_0000;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (do_write) begin
        aw_have <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (do_write) begin
        w_have <= 1'b0;
      end
    end
  end

  // Write response: one cycle after both halves are held
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Power-on only: manual reset does not reach these
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      timing <= TIMING_RESET;
      a5_wait_lo <= WAITLO_RESET;
      a6_wait_lo <= WAITLO_RESET;
      bus32 <= CONFIG_RESET_BUS32;
    end else begin
      if (wr_timing) begin
        timing <= timing_merge & ~TIMING_RSVD;
      end
      if (wr_waitlo && w_strb[0]) begin
        a5_wait_lo <= w_data[2:0];
        a6_wait_lo <= w_data[5:3];
      end
      if (wr_config && w_strb[0]) begin
        bus32 <= w_data[0];
      end
    end
  end

  // Mode settings have no reset at all; undefined until written
  always_ff @(posedge ref_clk) begin
    if (wr_mode && in_win_a2) begin
      mode_a2 <= mode_val[7:0];
    end
    if (wr_mode && in_win_a3) begin
      mode_a3 <= mode_val[7:0];
    end
  end

  // Mode-set command pulse to the addressed memory
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_set_cmd <= 1'b0;
      mode_set_area3 <= 1'b0;
      mode_set_addr <= 12'h000;
      last_mode <= 12'h000;
    end else begin
      mode_set_cmd <= wr_mode && manual_rst_n;
      if (wr_mode) begin
        mode_set_area3 <= in_win_a3;
        mode_set_addr <= mode_val;
        last_mode <= mode_val;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // AXI read path; mode windows read as zero since they are write only
  wire [31:0] rd_data =
    (s_axi_araddr == ADDR_TIMING) ? {16'h0000, timing & ~TIMING_RSVD} :
    (s_axi_araddr == ADDR_WAITLO) ? {26'h0, a6_wait_lo, a5_wait_lo} :
    (s_axi_araddr == ADDR_CONFIG) ? {31'h0, bus32} :
    (s_axi_araddr == ADDR_STATUS) ? {15'h0, card_busy, 4'h0, last_mode} :
    32'h0000_0000;
  wire rd_hit = (s_axi_araddr == ADDR_TIMING) ||
                (s_axi_araddr == ADDR_WAITLO) ||
                (s_axi_araddr == ADDR_CONFIG) ||
                (s_axi_araddr == ADDR_STATUS) ||
                ((s_axi_araddr & MODE_WIN_MASK) == MODE_BASE_A2) ||
                ((s_axi_araddr & MODE_WIN_MASK) == MODE_BASE_A3);
  assign s_axi_arready = !s_axi_rvalid;

  // Read answer one cycle after the address is taken
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_data;
      s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Card cycle sequencer, one ref_clk per bus half-cycle
  csm_seq_t state;
  csm_seq_t next_state;
  logic [7:0] cnt;
  logic [7:0] next_cnt;
  logic area6_q;

  wire [2:0] sel_ted = area6_q ? a6_ted : a5_ted;
  wire [2:0] sel_teh = area6_q ? a6_teh : a5_teh;
  wire [5:0] sel_wait = area6_q ? area6_wait_states : area5_wait_states;
  wire sel_pin_en = area6_q ? area6_wait_pin_en : area5_wait_pin_en;
  wire [2:0] req_ted = card_area6 ? a6_ted : a5_ted;
  // Strobe width in halves: whole bus cycles, one plus the waits
  wire [7:0] strobe_halves = {1'b0, 6'(sel_wait + 6'd1), 1'b0};
  wire stretch = sel_pin_en && card_wait;

  // Odd half counts put each strobe edge on the opposite phase
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    unique case (state)
      SEQ_IDLE: begin
        if (card_req) begin
          next_state = SEQ_SETUP;
          next_cnt = half_count(req_ted);
        end
      end
      SEQ_SETUP: begin
        next_cnt = 8'(cnt - 8'd1);
        if (cnt == 8'd1) begin
          next_state = SEQ_STROBE;
          next_cnt = strobe_halves;
        end
      end
      SEQ_STROBE: begin
        next_cnt = 8'(cnt - 8'd1);
        if (cnt == 8'd1 && stretch) begin
          next_cnt = 8'd2;
        end else if (cnt == 8'd1) begin
          next_state = SEQ_HOLD;
          next_cnt = half_count(sel_teh);
        end
      end
      SEQ_HOLD: begin
        next_cnt = 8'(cnt - 8'd1);
        if (cnt == 8'd1) begin
          next_state = SEQ_IDLE;
        end
      end
    endcase
  end

  // Sequencer state; manual reset abandons a cycle
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= SEQ_IDLE;
      cnt <= 8'h00;
      area6_q <= 1'b0;
      bus_clk_phase <= 1'b0;
    end else if (!manual_rst_n) begin
      state <= SEQ_IDLE;
      cnt <= 8'h00;
      bus_clk_phase <= ~bus_clk_phase;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      bus_clk_phase <= ~bus_clk_phase;
      if (state == SEQ_IDLE && card_req) begin
        area6_q <= card_area6;
      end
    end
  end

  // Pin outputs from flops
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      card_addr_valid <= 1'b0;
      card_strobe_n <= 1'b1;
      card_done <= 1'b0;
    end else begin
      card_addr_valid <= manual_rst_n && (next_state != SEQ_IDLE);
      card_strobe_n <= !(manual_rst_n && next_state == SEQ_STROBE);
      card_done <= manual_rst_n && state == SEQ_HOLD && cnt == 8'd1;
    end
  end
  assign card_busy = (state != SEQ_IDLE);

  ////////////////////////////////////////////////////////////////////////
  // Checks
  timing_rsvd_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (timing & TIMING_RSVD) == 16'h0000)
    else $error("reserved timing bits set");
  wait_table_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    a5_code == a6_code |-> area5_wait_states == area6_wait_states)
    else $error("area wait tables differ");
  wait_top_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    a5_code == 4'hf |-> area5_wait_states == 6'd38
      && area5_burst_states == 6'd39)
    else $error("top wait code wrong");
  burst_zero_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    a6_code == 4'h0 |-> area6_burst_states == 6'd2
      && !area6_wait_pin_en)
    else $error("code zero burst wrong");
  mode_shift_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wr_mode && manual_rst_n && bus32 |=> mode_set_cmd
      && mode_set_addr == {2'h0, $past(aw_addr[11:2])})
    else $error("mode value not shifted by two");
  mode_half_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wr_mode && !bus32 |=> mode_set_addr == {1'h0, $past(aw_addr[11:1])})
    else $error("mode value not shifted by one");
  mode_area_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wr_mode |=> mode_set_area3 == $past(in_win_a3))
    else $error("mode area decode wrong");
  mode_store_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wr_mode |=> ($past(in_win_a3) ? mode_a3 : mode_a2)
      == $past(mode_val[7:0]))
    else $error("mode setting not stored");
  setup_delay_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    state == SEQ_IDLE && card_req && manual_rst_n && req_ted == 3'h0
      |=> card_addr_valid && card_strobe_n ##1 !card_strobe_n)
    else $error("half-cycle assert delay wrong");
  hold_delay_a: assert property (@(posedge ref_clk)
    disable iff (!rst_n || !manual_rst_n)
    $rose(card_strobe_n) && card_addr_valid && sel_teh == 3'h1
      |-> card_addr_valid [*3] ##1 !card_addr_valid)
    else $error("address hold delay wrong");
  timing_keep_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !manual_rst_n && !wr_timing |=> $stable(timing))
    else $error("manual reset changed timing");

endmodule
`default_nettype wire

// >>> verification/csm_card_model.sv
// Behavioural card slot and SDRAM on the far side of the block.
// Assumes the bench reads the measured edge spacings after each cycle.
`timescale 1ns/1ps
`default_nettype none
module csm_card_model (
  // Clock
  input wire logic ref_clk,
  // Card strobes and wait request
  input wire logic card_addr_valid,
  input wire logic card_strobe_n,
  input wire logic card_done,
  input wire logic wait_hold,
  output logic card_wait,
  // Mode-set command
  input wire logic mode_set_cmd,
  input wire logic mode_set_area3,
  input wire logic [11:0] mode_set_addr,
  // Measured results: edge spacings in ref_clk cycles, then mode-set count and last command
  output int t_set,
  output int t_low,
  output int t_hold,
  output int t_done,
  output int mode_cnt,
  output logic [11:0] last_mode,
  output logic last_area3
);
  int cyc;
  int t_av;
  int t_sf;
  int t_sr;
  int t_dn;
  logic prev_av;
  logic prev_st;
  //////////////////////////////////////////////////////////////////////////
  // Unselected card releases the pin, so it wanders instead of holding
  assign card_wait = card_addr_valid ? wait_hold : cyc[0];
  assign t_done = t_dn - t_sr;
  // Edge times of each card cycle
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    prev_av <= card_addr_valid;
    prev_st <= card_strobe_n;
    if (card_addr_valid && !prev_av) t_av <= cyc;
    if (!card_strobe_n && prev_st) t_sf <= cyc;
    if (card_strobe_n && !prev_st) t_sr <= cyc;
    if (card_done) t_dn <= cyc;
    if (!card_addr_valid && prev_av) begin
      t_set <= t_sf - t_av;
      t_low <= t_sr - t_sf;
      t_hold <= cyc - t_sr;
    end
  end
  // Memory latches each mode-set command
  always @(posedge ref_clk) begin
    if (mode_set_cmd) begin
      mode_cnt <= mode_cnt + 1;
      last_mode <= mode_set_addr;
      last_area3 <= mode_set_area3;
    end
  end
endmodule
`default_nettype wire

// >>> verification/csm_card_timing_tb_top.sv
// Self-checking bench for the card strobe timing and mode-set block.
// Assumes the card model beside it; registers reached over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module csm_card_timing_tb_top;
  import csm_pkg::*;
  logic ref_clk, arst_n, manual_rst_n, card_req, card_area6, card_wait;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, wait_hold, bus_clk_phase;
  logic card_busy, card_addr_valid, card_strobe_n, card_done;
  logic [5:0] area5_wait_states, area5_burst_states;
  logic [5:0] area6_wait_states, area6_burst_states;
  logic area5_wait_pin_en, area6_wait_pin_en, mode_set_cmd, mode_set_area3;
  logic [11:0] mode_set_addr, last_mode;
  logic last_area3;
  int t_set, t_low, t_hold, t_done, mode_cnt, err_count, compares;
  int wt[16] = '{0, 1, 2, 3, 4, 6, 8, 10, 12, 14, 18, 22, 26, 30, 34, 38};
  int d5[2] = '{0, 7};
  int h5[2] = '{0, 7};
  int d6[2] = '{7, 3};
  int h6[2] = '{7, 1};
  //////////////////////////////////////////////////////////////////////////
  csm_card_timing u_csm_card_timing (
    .ref_clk(ref_clk), .arst_n(arst_n), .manual_rst_n(manual_rst_n),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .card_req(card_req),
    .card_area6(card_area6), .card_wait(card_wait), .card_busy(card_busy),
    .card_addr_valid(card_addr_valid), .card_strobe_n(card_strobe_n),
    .card_done(card_done), .bus_clk_phase(bus_clk_phase),
    .area5_wait_states(area5_wait_states),
    .area5_burst_states(area5_burst_states),
    .area5_wait_pin_en(area5_wait_pin_en),
    .area6_wait_states(area6_wait_states),
    .area6_burst_states(area6_burst_states),
    .area6_wait_pin_en(area6_wait_pin_en), .mode_set_cmd(mode_set_cmd),
    .mode_set_area3(mode_set_area3), .mode_set_addr(mode_set_addr));
  csm_card_model u_csm_card_model (
    .ref_clk(ref_clk), .card_addr_valid(card_addr_valid),
    .card_strobe_n(card_strobe_n), .card_done(card_done),
    .wait_hold(wait_hold), .card_wait(card_wait),
    .mode_set_cmd(mode_set_cmd), .mode_set_area3(mode_set_area3),
    .mode_set_addr(mode_set_addr), .t_set(t_set), .t_low(t_low),
    .t_hold(t_hold), .t_done(t_done), .mode_cnt(mode_cnt),
    .last_mode(last_mode), .last_area3(last_area3));
  //////////////////////////////////////////////////////////////////////////
  // Free-running 200 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  // Hang guard, well past the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge ref_clk);
    err_count++;
    give_verdict();
  end
  task automatic check(input logic [31:0] got, exp, input string msg);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  task give_verdict;
    if (err_count == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Address and data offered together, each dropped once taken
  task automatic axi_write(input logic [31:0] a, d, output logic [1:0] r);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge ref_clk);
      if (!aw_ok && s_axi_awready === 1'b1) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_ok && s_axi_wready === 1'b1) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    while (s_axi_bvalid !== 1'b1) @(posedge ref_clk);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic axi_read(input logic [31:0] a, output logic [31:0] d,
                          output logic [1:0] r);
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge ref_clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge ref_clk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  // Timing word from per-area assert and hold delay codes
  function automatic logic [31:0] tword(input int a, b, c, e);
    return {16'h0, 4'h0, a[2], c[2], b[2], e[2], a[1], a[0], c[1], c[0],
            b[1], b[0], e[1], e[0]};
  endfunction
  // One card cycle, then its edge spacings from the model
  task automatic card_run(input logic a6, input int ted, teh, w,
                          input logic hold);
    int n;
    n = 0;
    @(posedge ref_clk);
    wait_hold <= hold;
    card_area6 <= a6;
    card_req <= 1'b1;
    @(posedge ref_clk);
    card_req <= 1'b0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (card_busy !== 1'b0 && n < 400);
    repeat (3) @(posedge ref_clk);
    check(32'(n < 400), 32'h1, "card hung");
    check(t_set, 2 * ted + 1, "assert delay");
    check(t_low, 2 * (w + 1), "strobe width");
    check(t_hold, 2 * teh + 1, "addr hold");
    check(t_done, 2 * teh + 1, "done point");
  endtask
  // Mode write; memory must see one command with the shifted offset
  task automatic mode_case(input logic [31:0] a, d, input logic [11:0] v,
                           input logic a3);
    int n0;
    n0 = mode_cnt;
    axi_write(a, d, rs);
    @(posedge ref_clk);
    check(32'(rs), 32'(RESP_OKAY), "mode resp");
    check(mode_cnt, n0 + 1, "mode cmd");
    check(32'(last_mode), 32'(v), "mode value");
    check(32'(last_area3), 32'(a3), "mode area");
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    {arst_n, card_req, card_area6, wait_hold} = '0;
    manual_rst_n = 1'b1;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hf;
    repeat (10) @(posedge ref_clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    axi_read(ADDR_TIMING, rd, rs);
    check(rd, 32'h0, "timing reset");
    axi_read(ADDR_WAITLO, rd, rs);
    check({26'h0, rd[5:0]}, 32'h3f, "wait reset");
    // Bus clock phase flips on every rising ref_clk edge
    rd[0] = bus_clk_phase;
    @(posedge ref_clk);
    check({31'h0, bus_clk_phase}, {31'h0, !rd[0]}, "bus phase");
    // Reserved bits stay zero whatever is written
    axi_write(ADDR_TIMING, 32'hffff, rs);
    axi_read(ADDR_TIMING, rd, rs);
    check(rd, 32'hcfff, "reserved bits");
    axi_read(32'h10, rd, rs);
    check(32'(rs), 32'(RESP_SLVERR), "unmapped read");
    axi_write(32'h14, 32'h1, rs);
    check(32'(rs), 32'(RESP_SLVERR), "unmapped write");
    // Every wait code on both areas; high bit only set with card areas
    for (int c = 0; c < 16; c++) begin
      axi_write(ADDR_TIMING, {16'h0, c[3], c[3], 14'h0}, rs);
      axi_write(ADDR_WAITLO, {26'h0, c[2:0], c[2:0]}, rs);
      @(posedge ref_clk);
      check(32'(area5_wait_states), wt[c], "a5 waits");
      check(32'(area5_burst_states), c == 0 ? 2 : wt[c] + 1, "a5 burst");
      check(32'(area5_wait_pin_en), 32'(c != 0), "a5 pin");
      check(32'(area6_wait_states), wt[c], "a6 waits");
      check(32'(area6_burst_states), c == 0 ? 2 : wt[c] + 1, "a6 burst");
      check(32'(area6_wait_pin_en), 32'(c != 0), "a6 pin");
    end
    // Area 5 code 0 ignores a held wait pin; area 6 code 1 runs with the pin released
    axi_write(ADDR_WAITLO, 32'h08, rs);
    for (int i = 0; i < 2; i++) begin
      axi_write(ADDR_TIMING, tword(d5[i], h5[i], d6[i], h6[i]), rs);
      card_run(1'b0, d5[i], h5[i], 0, 1'b1);
      card_run(1'b1, d6[i], h6[i], 1, 1'b0);
    end
    axi_write(ADDR_CONFIG, 32'h1, rs);
    mode_case(MODE_BASE_A2 + 32'h8c0, 32'hdead_beef, 12'h230, 1'b0);
    mode_case(MODE_BASE_A3 + 32'hffc, 32'h0, 12'h3ff, 1'b1);
    axi_write(ADDR_CONFIG, 32'h0, rs);
    mode_case(MODE_BASE_A3 + 32'h8c0, 32'h5a5a_5a5a, 12'h460, 1'b1);
    axi_read(MODE_BASE_A2 + 32'h8c0, rd, rs);
    check(rd, 32'h0, "mode readback");
    // Manual reset keeps settings; power-on clears the timing word
    manual_rst_n <= 1'b0;
    repeat (3) @(posedge ref_clk);
    manual_rst_n <= 1'b1;
    axi_read(ADDR_TIMING, rd, rs);
    check(rd, tword(7, 7, 3, 1), "manual keep");
    axi_read(ADDR_STATUS, rd, rs);
    check({20'h0, rd[11:0]}, 32'h460, "mode kept");
    arst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    axi_read(ADDR_TIMING, rd, rs);
    check(rd, 32'h0, "power-on clear");
    give_verdict();
  end
endmodule
`default_nettype wire
